// ==== hdl/pbmx_pin_cell.sv ====
// Override logic of one port pin: pull-up, driver, value, toggle, input gate
`timescale 1ns/1ps
module pbmx_pin_cell (
    // Port register bits and globals
    input wire logic pinDirectionBit,
    input wire logic pinOutputBit,
    input wire logic globalPullupOff,
    input wire logic sleepClamp,
    input wire logic inReset,
    // Overrides from the owning peripheral
    input wire logic pullupOverrideEn,
    input wire logic pullupOverrideVal,
    input wire logic driveOverrideEn,
    input wire logic driveOverrideVal,
    input wire logic valueOverrideEn,
    input wire logic valueOverrideVal,
    input wire logic toggleOverrideEn,
    input wire logic inputGateOverrideEn,
    input wire logic inputGateOverrideVal,
    // Pad side
    input wire logic padIn,
    output logic padOut,
    output logic padOe,
    output logic padPullup,
    output logic altInputTap
);
    import pbmx_pkg::*;

    logic outBit;
    logic driveEn;
    logic inputEn;

    // Inverted bit seen by the pad; the stored bit is left as written
    assign outBit = pinOutputBit ^ toggleOverrideEn;
    assign driveEn = driveOverrideEn ? driveOverrideVal : pinDirectionBit;
    // Reset tri-states the pad even before the first clock edge
    assign padOe = driveEn & ~inReset;
    assign padOut = valueOverrideEn ? valueOverrideVal : outBit;
    assign padPullup = ~inReset & (pullupOverrideEn ? pullupOverrideVal
        : (~pinDirectionBit & outBit & ~globalPullupOff));
    assign inputEn = inputGateOverrideEn ? inputGateOverrideVal : ~sleepClamp;
    // Clamp to ground ahead of the synchronizer; the tap is unsynchronized
    assign altInputTap = padIn & inputEn;
endmodule

// ==== hdl/pbmx_port_b.sv ====
// Port B pin multiplexer with APB registers and external interrupt flags
`timescale 1ns/1ps
module pbmx_port_b (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOe,
    output logic [7:0] padPullup,
    // Sleep controller
    input wire logic sleepClamp,
    // SPI
    input wire logic spiEnable,
    input wire logic spiMaster,
    input wire logic spiClkOut,
    input wire logic spiMosiOut,
    input wire logic spiMisoOut,
    output logic spiClkIn,
    output logic spiMosiIn,
    output logic spiMisoIn,
    // Power stage outputs
    input wire logic stage0Out1En,
    input wire logic stage0Out1,
    input wire logic stage1Out1En,
    input wire logic stage1Out1,
    input wire logic stage2Out1En,
    input wire logic stage2Out1,
    input wire logic stage2Out0En,
    input wire logic stage2Out0,
    // Timer capture, analog input disables, generic toggle overrides
    output logic timer1AltCaptureIn,
    input wire logic [7:0] analogDigitalOff,
    input wire logic [7:0] toggleOverrideEn,
    // External interrupts
    output logic extIrqOneTap,
    output logic extIrqTwoTap,
    output logic [1:0] extIrqFlags
);
    import pbmx_pkg::*;

    pbmx_state_t state_reg;
    pbmx_state_t state_next;

    logic inReset;
    logic [7:0] pullupOverrideEn;
    logic [7:0] pullupOverrideVal;
    logic [7:0] driveOverrideEn;
    logic [7:0] driveOverrideVal;
    logic [7:0] valueOverrideEn;
    logic [7:0] valueOverrideVal;
    logic [7:0] inputGateOverrideEn;
    logic [7:0] inputGateOverrideVal;
    logic [7:0] altInputTap;
    logic [7:0] pinInputBits;
    logic globalPullupOff;
    logic irqOneEn;
    logic irqTwoEn;
    logic spiSlave;
    logic spiMasterOn;
    logic setupRead;
    logic accessWrite;
    logic addrMapped;
    logic [1:0] irqSet;
    logic [1:0] irqLevel;

    function automatic logic edgeHit(input logic [1:0] sense, input logic prev,
        input logic now);
        logic hit;
        hit = 1'b0;
        unique case (pbmx_sense_t'(sense))
            PBMX_SENSE_LOW: hit = 1'b0;
            PBMX_SENSE_ANY: hit = prev ^ now;
            PBMX_SENSE_FALL: hit = prev & ~now;
            PBMX_SENSE_RISE: hit = ~prev & now;
        endcase
        return hit;
    endfunction

    function automatic logic [31:0] widen(input logic [7:0] value);
        return {24'h000000, value};
    endfunction

    assign inReset = ~reset_n;
    assign globalPullupOff = state_reg.mcuCtl[PBMX_PUD_BIT];
    assign irqOneEn = state_reg.irqCtl[PBMX_IRQ1_EN_BIT];
    assign irqTwoEn = state_reg.irqCtl[PBMX_IRQ2_EN_BIT];
    assign spiSlave = spiEnable & ~spiMaster;
    assign spiMasterOn = spiEnable & spiMaster;

    // Override table of port B; peripherals hold their enables low when idle
    always_comb
    begin
        pullupOverrideEn = 8'h00;
        pullupOverrideVal = 8'h00;
        driveOverrideEn = 8'h00;
        driveOverrideVal = 8'h00;
        valueOverrideEn = 8'h00;
        valueOverrideVal = 8'h00;
        inputGateOverrideEn = analogDigitalOff;
        inputGateOverrideVal = 8'h00;
        // Pin 7: power stage 0 output 1 wins over the SPI clock
        pullupOverrideEn[PBMX_PIN_SCK] = spiSlave & ~stage0Out1En;
        pullupOverrideVal[PBMX_PIN_SCK] = state_reg.outBits[PBMX_PIN_SCK]
            & ~globalPullupOff;
        driveOverrideEn[PBMX_PIN_SCK] = spiSlave | stage0Out1En;
        driveOverrideVal[PBMX_PIN_SCK] = stage0Out1En;
        valueOverrideEn[PBMX_PIN_SCK] = stage0Out1En | spiMasterOn;
        valueOverrideVal[PBMX_PIN_SCK] = stage0Out1En ? stage0Out1 : spiClkOut;
        // Pin 6: power stage 1 output 1 forces the driver on
        driveOverrideEn[PBMX_PIN_CAPT] = stage1Out1En;
        driveOverrideVal[PBMX_PIN_CAPT] = 1'b1;
        valueOverrideEn[PBMX_PIN_CAPT] = stage1Out1En;
        valueOverrideVal[PBMX_PIN_CAPT] = stage1Out1;
        // Interrupt pins keep their input alive in sleep when enabled
        inputGateOverrideEn[PBMX_PIN_IRQ2] = analogDigitalOff[PBMX_PIN_IRQ2] | irqTwoEn;
        inputGateOverrideVal[PBMX_PIN_IRQ2] = irqTwoEn;
        inputGateOverrideEn[PBMX_PIN_IRQ1] = analogDigitalOff[PBMX_PIN_IRQ1] | irqOneEn;
        inputGateOverrideVal[PBMX_PIN_IRQ1] = irqOneEn;
        // Pin 1: slave input, master drives MOSI, stage 2 output 1 wins
        pullupOverrideEn[PBMX_PIN_MOSI] = spiSlave & ~stage2Out1En;
        pullupOverrideVal[PBMX_PIN_MOSI] = state_reg.outBits[PBMX_PIN_MOSI] & ~globalPullupOff;
        driveOverrideEn[PBMX_PIN_MOSI] = spiSlave | stage2Out1En;
        driveOverrideVal[PBMX_PIN_MOSI] = stage2Out1En;
        valueOverrideEn[PBMX_PIN_MOSI] = stage2Out1En | spiMasterOn;
        valueOverrideVal[PBMX_PIN_MOSI] = stage2Out1En ? stage2Out1 : spiMosiOut;
        // Pin 0: master input, slave drives MISO, stage 2 output 0 wins
        pullupOverrideEn[PBMX_PIN_MISO] = spiMasterOn & ~stage2Out0En;
        pullupOverrideVal[PBMX_PIN_MISO] = state_reg.outBits[PBMX_PIN_MISO]
            & ~globalPullupOff;
        driveOverrideEn[PBMX_PIN_MISO] = spiMasterOn | stage2Out0En;
        driveOverrideVal[PBMX_PIN_MISO] = stage2Out0En;
        valueOverrideEn[PBMX_PIN_MISO] = stage2Out0En | spiSlave;
        valueOverrideVal[PBMX_PIN_MISO] = stage2Out0En ? stage2Out0 : spiMisoOut;
    end

    for (genvar i = 0; i < PBMX_PINS; i++)
    begin : gen_pin
        pbmx_pin_cell u_cell (
            .pinDirectionBit(state_reg.dirBits[i]),
            .pinOutputBit(state_reg.outBits[i]),
            .globalPullupOff(globalPullupOff),
            .sleepClamp(sleepClamp),
            .inReset(inReset),
            .pullupOverrideEn(pullupOverrideEn[i]),
            .pullupOverrideVal(pullupOverrideVal[i]),
            .driveOverrideEn(driveOverrideEn[i]),
            .driveOverrideVal(driveOverrideVal[i]),
            .valueOverrideEn(valueOverrideEn[i]),
            .valueOverrideVal(valueOverrideVal[i]),
            .toggleOverrideEn(toggleOverrideEn[i]),
            .inputGateOverrideEn(inputGateOverrideEn[i]),
            .inputGateOverrideVal(inputGateOverrideVal[i]),
            .padIn(padIn[i]),
            .padOut(padOut[i]),
            .padOe(padOe[i]),
            .padPullup(padPullup[i]),
            .altInputTap(altInputTap[i])
        );
    end

    // Peripherals get the raw taps and synchronize them themselves
    assign spiClkIn = altInputTap[PBMX_PIN_SCK];
    assign timer1AltCaptureIn = altInputTap[PBMX_PIN_CAPT];
    assign extIrqTwoTap = altInputTap[PBMX_PIN_IRQ2];
    assign extIrqOneTap = altInputTap[PBMX_PIN_IRQ1];
    assign spiMosiIn = altInputTap[PBMX_PIN_MOSI];
    assign spiMisoIn = altInputTap[PBMX_PIN_MISO];

    // Clamped level is what gets synchronized, so wake-up looks like an edge
    pbmx_sync #(
        .WIDTH(PBMX_PINS)
    ) u_pin_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(altInputTap),
        .syncOut(pinInputBits)
    );

    assign irqLevel = {pinInputBits[PBMX_PIN_IRQ2], pinInputBits[PBMX_PIN_IRQ1]};
    // Flags are set whether or not the interrupt is enabled
    assign irqSet[0] = edgeHit(state_reg.irqCtl[PBMX_IRQ1_SENSE_LO +: 2],
        state_reg.irqPrev[0], irqLevel[0]);
    assign irqSet[1] = edgeHit(state_reg.irqCtl[PBMX_IRQ2_SENSE_LO +: 2],
        state_reg.irqPrev[1], irqLevel[1]);

    // APB: zero wait states, read data captured in the setup cycle
    assign setupRead = psel & ~penable & ~pwrite;
    assign accessWrite = psel & penable & pwrite;
    assign addrMapped = (paddr == PBMX_OFS_OUT) || (paddr == PBMX_OFS_DIR)
        || (paddr == PBMX_OFS_PIN) || (paddr == PBMX_OFS_MCUCTL)
        || (paddr == PBMX_OFS_IRQCTL) || (paddr == PBMX_OFS_IRQFLG);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addrMapped;

    always_comb
    begin
        state_next = state_reg;
        state_next.irqPrev = irqLevel;
        state_next.irqFlags = state_reg.irqFlags | irqSet;
        if (accessWrite)
        begin
            unique case (paddr)
                PBMX_OFS_OUT: state_next.outBits = pwdata[7:0];
                PBMX_OFS_DIR: state_next.dirBits = pwdata[7:0];
                // Writing ones here toggles the output bits
                PBMX_OFS_PIN: state_next.outBits = state_reg.outBits ^ pwdata[7:0];
                PBMX_OFS_MCUCTL: state_next.mcuCtl = pwdata[7:0];
                PBMX_OFS_IRQCTL: state_next.irqCtl = pwdata[7:0];
                // A new edge in the clearing cycle keeps its flag
                PBMX_OFS_IRQFLG: state_next.irqFlags = (state_reg.irqFlags & ~pwdata[1:0])
                    | irqSet;
                default: state_next.irqFlags = state_reg.irqFlags | irqSet;
            endcase
        end
        if (setupRead)
        begin
            unique case (paddr)
                PBMX_OFS_OUT: state_next.rdData = widen(state_reg.outBits);
                PBMX_OFS_DIR: state_next.rdData = widen(state_reg.dirBits);
                PBMX_OFS_PIN: state_next.rdData = widen(pinInputBits);
                PBMX_OFS_MCUCTL: state_next.rdData = widen(state_reg.mcuCtl);
                PBMX_OFS_IRQCTL: state_next.rdData = widen(state_reg.irqCtl);
                PBMX_OFS_IRQFLG: state_next.rdData = {30'h0, state_reg.irqFlags};
                default: state_next.rdData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state_reg.outBits <= PBMX_RST_OUT;
            state_reg.dirBits <= PBMX_RST_DIR;
            state_reg.mcuCtl <= PBMX_RST_MCUCTL;
            state_reg.irqCtl <= PBMX_RST_IRQCTL;
            state_reg.irqFlags <= PBMX_RST_IRQFLG;
            state_reg.irqPrev <= 2'h0;
            state_reg.rdData <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdData;
    assign extIrqFlags = state_reg.irqFlags;
endmodule

// ==== hdl/pbmx_sync.sv ====
// Two-flop synchronizer for pad levels entering the core clock domain
`timescale 1ns/1ps
module pbmx_sync #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import pbmx_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pbmx_sync_t;

    pbmx_sync_t state_reg;
    pbmx_sync_t state_next;

    // First stage feeds only the second stage
    always_comb
    begin
        state_next.stage1 = asyncIn;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign syncOut = state_reg.stage2;
endmodule

// ==== inc/pbmx_pkg.sv ====
// Constants and types of the port B alternate-function override block
// How it works
// - Sleep clamp forces each pin's digital input to zero in deep sleep.
// - A pin with its external interrupt enabled escapes the sleep clamp.
// - Disabled edge-sensed interrupt pin held high sets its flag: rising on wake, falling on clamp entry, any change on both.
// - Without pull-up override, pull-up on only for dir 0, out 1, global off 0.
// - With pull-up override, pull-up follows override value alone.
// - Driver enable comes from direction bit, or override value when overridden.
// - Overridden driver is on for value one, off for zero.
// - Driven level is override value if value override set, else output bit.
// - Value override replaces the output bit at the pad.
// - Toggle override inverts the pin's output bit.
// - Input enable follows sleep state unless its override is enabled.
// - Overridden input enable follows override value in any state.
// - Alternate input taps ahead of the synchronizer; receivers synchronize.
// - Global pull-up off bit 4 of MCU control disables all pull-ups.
// - SPI slave forces pin 7 to input; pull-up still from output bit.
// - Pin 7 stage0 out1 and SPI clock, 6 capture and stage1, 5 irq two.
// - Pin 2 irq one, 1 MOSI and stage2 out1, 0 MISO and stage2 out0.
// - Without overrides, direction one drives output bit, zero makes an input.
// - SPI master forces pin 0 to input; slave uses the direction bit.
package pbmx_pkg;

    localparam int unsigned PBMX_PINS = 8;

    localparam logic [7:0] PBMX_OFS_OUT = 8'h00;
    localparam logic [7:0] PBMX_OFS_DIR = 8'h04;
    localparam logic [7:0] PBMX_OFS_PIN = 8'h08;
    localparam logic [7:0] PBMX_OFS_MCUCTL = 8'h0c;
    localparam logic [7:0] PBMX_OFS_IRQCTL = 8'h10;
    localparam logic [7:0] PBMX_OFS_IRQFLG = 8'h14;

    localparam logic [7:0] PBMX_RST_OUT = 8'h00;
    localparam logic [7:0] PBMX_RST_DIR = 8'h00;
    localparam logic [7:0] PBMX_RST_MCUCTL = 8'h00;
    localparam logic [7:0] PBMX_RST_IRQCTL = 8'h00;
    localparam logic [1:0] PBMX_RST_IRQFLG = 2'h0;

    localparam int unsigned PBMX_PUD_BIT = 4;
    localparam int unsigned PBMX_IRQ1_EN_BIT = 0;
    localparam int unsigned PBMX_IRQ2_EN_BIT = 1;
    localparam int unsigned PBMX_IRQ1_SENSE_LO = 2;
    localparam int unsigned PBMX_IRQ2_SENSE_LO = 4;

    localparam int unsigned PBMX_PIN_SCK = 7;
    localparam int unsigned PBMX_PIN_CAPT = 6;
    localparam int unsigned PBMX_PIN_IRQ2 = 5;
    localparam int unsigned PBMX_PIN_IRQ1 = 2;
    localparam int unsigned PBMX_PIN_MOSI = 1;
    localparam int unsigned PBMX_PIN_MISO = 0;

    localparam int unsigned PBMX_SYNC_STAGES = 2;

    // Sense field codes: low level, any change, falling, rising
    typedef enum logic [1:0] {
        PBMX_SENSE_LOW,
        PBMX_SENSE_ANY,
        PBMX_SENSE_FALL,
        PBMX_SENSE_RISE
    } pbmx_sense_t;

    typedef struct packed {
        logic [7:0] outBits;
        logic [7:0] dirBits;
        logic [7:0] mcuCtl;
        logic [7:0] irqCtl;
        logic [1:0] irqFlags;
        logic [1:0] irqPrev;
        logic [31:0] rdData;
    } pbmx_state_t;

endpackage

// ==== verification/pbmx_periph_model.sv ====
// Behavioural model of the peripherals owning port B alternate functions
`timescale 1ns/1ps
module pbmx_periph_model (
    // Clock, reset, scenario: 0 idle, 1 SPI slave, 2 SPI master, 3 power stages
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [1:0] mode,
    // SPI
    output logic spiEnable,
    output logic spiMaster,
    output logic spiClkOut,
    output logic spiMosiOut,
    output logic spiMisoOut,
    // Power stages
    output logic stage0Out1En,
    output logic stage0Out1,
    output logic stage1Out1En,
    output logic stage1Out1,
    output logic stage2Out1En,
    output logic stage2Out1,
    output logic stage2Out0En,
    output logic stage2Out0
);
    logic [3:0] wave;
    // wave[0] levels change every cycle, the others at least every second cycle, so a stale pin value cannot pass
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            wave <= 4'h0;
        else
            wave <= wave + 4'h5;
    end
    assign spiEnable = mode == 2'd1 || mode == 2'd2;
    assign spiMaster = mode == 2'd2;
    assign spiClkOut = wave[0];
    assign spiMosiOut = wave[1];
    assign spiMisoOut = wave[2];
    assign stage0Out1En = mode == 2'd3;
    assign stage1Out1En = mode == 2'd3;
    assign stage2Out1En = mode == 2'd3;
    assign stage2Out0En = mode == 2'd3;
    assign stage0Out1 = wave[0];
    assign stage1Out1 = wave[1];
    assign stage2Out1 = wave[2];
    assign stage2Out0 = wave[3];
endmodule

// ==== verification/pbmx_port_b_asserts.sv ====
// Port-level checker of the port B override block
`timescale 1ns/1ps
module pbmx_port_b_asserts (
    // Clock, reset, APB
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    // Pads and sleep
    input wire logic [7:0] padIn,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullup,
    input wire logic sleepClamp,
    // Peripherals and taps
    input wire logic spiEnable,
    input wire logic spiMaster,
    input wire logic stage0Out1En,
    input wire logic stage1Out1En,
    input wire logic stage1Out1,
    input wire logic stage2Out1En,
    input wire logic stage2Out0En,
    input wire logic spiClkIn,
    input wire logic timer1AltCaptureIn,
    input wire logic [7:0] analogDigitalOff,
    input wire logic [7:0] toggleOverrideEn,
    input wire logic extIrqOneTap
);
    import pbmx_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic mapped;
    logic noOvr;
    assign mapped = paddr inside {PBMX_OFS_OUT, PBMX_OFS_DIR, PBMX_OFS_PIN, PBMX_OFS_MCUCTL,
                                  PBMX_OFS_IRQCTL, PBMX_OFS_IRQFLG};
    // Pin 3 has no owner, so outside APB writes any flip there comes from the toggle alone
    assign noOvr = !spiEnable && !stage0Out1En && !stage1Out1En && !stage2Out1En && !stage2Out0En;
    unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error response does not match address map");
    capture_clamp_a: assert property (timer1AltCaptureIn ==
        (padIn[6] && !sleepClamp && !analogDigitalOff[6])) else $error("capture tap gating wrong");
    stage_drive_a: assert property (stage1Out1En |-> padOe[6])
        else $error("stage output not driving pin 6");
    stage_value_a: assert property (stage1Out1En |-> padOut[6] == stage1Out1)
        else $error("pin 6 level not the stage value");
    slave_sck_dir_a: assert property (spiEnable && !spiMaster && !stage0Out1En |-> !padOe[7])
        else $error("slave clock pin still driven");
    master_miso_a: assert property (spiEnable && spiMaster && !stage2Out0En |-> !padOe[0])
        else $error("master data-in pin still driven");
    pullup_excl_a: assert property (noOvr |-> (padPullup & padOe) == 8'h00)
        else $error("pull-up on a driven pin");
    toggle_flip_a: assert property ($changed(toggleOverrideEn[3]) && $past(reset_n) &&
        !$past(psel) && padOe[3] |-> padOut[3] != $past(padOut[3])) else $error("toggle ignored");
    irq_tap_a: assert property (!sleepClamp && !analogDigitalOff[2] |->
        extIrqOneTap == padIn[2]) else $error("irq one tap not the pad level");
    sck_in_a: assert property (spiEnable && !spiMaster && !sleepClamp &&
        !analogDigitalOff[7] |-> spiClkIn == padIn[7]) else $error("slave clock tap wrong");
    stage_c: cover property (stage1Out1En && padOe[6]);
    slave_c: cover property (spiEnable && !spiMaster);
    clamp_c: cover property (sleepClamp ##1 !sleepClamp);
    err_c: cover property (pslverr);
endmodule
bind pbmx_port_b pbmx_port_b_asserts pbmx_port_b_asserts_i (.core_clk(core_clk),
    .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .sleepClamp(sleepClamp), .spiEnable(spiEnable), .spiMaster(spiMaster),
    .stage0Out1En(stage0Out1En), .stage1Out1En(stage1Out1En), .stage1Out1(stage1Out1),
    .stage2Out1En(stage2Out1En), .stage2Out0En(stage2Out0En), .spiClkIn(spiClkIn),
    .timer1AltCaptureIn(timer1AltCaptureIn), .analogDigitalOff(analogDigitalOff),
    .toggleOverrideEn(toggleOverrideEn), .extIrqOneTap(extIrqOneTap));

// ==== verification/pbmx_port_b_tb.sv ====
// Self-checking testbench of the port B override block
`timescale 1ns/1ps
module pbmx_port_b_tb;
    import pbmx_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, padIn = 8'h00, analogDigitalOff = 8'h00;
    logic [7:0] toggleOverrideEn = 8'h00, padOut, padOe, padPullup;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, sleepClamp = 1'b0, timer1AltCaptureIn, extIrqOneTap, extIrqTwoTap;
    logic [1:0] mode = 2'd0, extIrqFlags;
    logic spiEnable, spiMaster, spiClkOut, spiMosiOut, spiMisoOut, spiClkIn, spiMosiIn, spiMisoIn;
    logic stage0Out1En, stage0Out1, stage1Out1En, stage1Out1;
    logic stage2Out1En, stage2Out1, stage2Out0En, stage2Out0;
    int errors = 0, check_count = 0;
    always #5 core_clk = ~core_clk;
    pbmx_periph_model pbmx_periph_model_i (.core_clk(core_clk), .reset_n(reset_n), .mode(mode),
        .spiEnable(spiEnable), .spiMaster(spiMaster), .spiClkOut(spiClkOut),
        .spiMosiOut(spiMosiOut), .spiMisoOut(spiMisoOut), .stage0Out1En(stage0Out1En),
        .stage0Out1(stage0Out1), .stage1Out1En(stage1Out1En), .stage1Out1(stage1Out1),
        .stage2Out1En(stage2Out1En), .stage2Out1(stage2Out1), .stage2Out0En(stage2Out0En),
        .stage2Out0(stage2Out0));
    pbmx_port_b pbmx_port_b_i (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullup(padPullup), .sleepClamp(sleepClamp), .spiEnable(spiEnable),
        .spiMaster(spiMaster), .spiClkOut(spiClkOut), .spiMosiOut(spiMosiOut),
        .spiMisoOut(spiMisoOut), .spiClkIn(spiClkIn), .spiMosiIn(spiMosiIn),
        .spiMisoIn(spiMisoIn), .stage0Out1En(stage0Out1En), .stage0Out1(stage0Out1),
        .stage1Out1En(stage1Out1En), .stage1Out1(stage1Out1), .stage2Out1En(stage2Out1En),
        .stage2Out1(stage2Out1), .stage2Out0En(stage2Out0En), .stage2Out0(stage2Out0),
        .timer1AltCaptureIn(timer1AltCaptureIn), .analogDigitalOff(analogDigitalOff),
        .toggleOverrideEn(toggleOverrideEn), .extIrqOneTap(extIrqOneTap),
        .extIrqTwoTap(extIrqTwoTap), .extIrqFlags(extIrqFlags));
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; released only after pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic t_regs();
        logic [7:0] ofs [6];
        ofs = '{PBMX_OFS_OUT, PBMX_OFS_DIR, PBMX_OFS_PIN, PBMX_OFS_MCUCTL, PBMX_OFS_IRQCTL,
            PBMX_OFS_IRQFLG};
        foreach (ofs[i])
            rd(ofs[i], 32'h0, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
    endtask
    task automatic t_gpio();
        apb(1'b1, PBMX_OFS_DIR, 32'h0f);
        apb(1'b1, PBMX_OFS_OUT, 32'hffff_ff5a);
        rd(PBMX_OFS_OUT, 32'h5a, 1'b0);
        @(negedge core_clk);
        chk(padOe, 8'h0f);
        chk(padOut & 8'h0f, 8'h0a);
        chk(padPullup, 8'h50);
        apb(1'b1, PBMX_OFS_MCUCTL, 32'h1 << PBMX_PUD_BIT);
        @(negedge core_clk);
        chk(padPullup, 8'h00);
        apb(1'b1, PBMX_OFS_MCUCTL, 32'h0);
        @(posedge core_clk);
        toggleOverrideEn <= 8'h0f;
        @(negedge core_clk);
        chk(padOut & 8'h0f, 8'h05);
        apb(1'b1, PBMX_OFS_PIN, 32'h03);
        rd(PBMX_OFS_OUT, 32'h59, 1'b0);
        toggleOverrideEn <= 8'h00;
        padIn <= 8'ha5;
        repeat (3) @(posedge core_clk);
        rd(PBMX_OFS_PIN, 32'ha5, 1'b0);
    endtask
    task automatic t_stage();
        apb(1'b1, PBMX_OFS_DIR, 32'h0);
        mode <= 2'd3;
        repeat (3)
        begin
            @(negedge core_clk);
            chk(padOe, 8'hc3);
            chk(padOut & 8'hc3, {stage0Out1, stage1Out1, 4'h0, stage2Out1, stage2Out0});
        end
        @(posedge core_clk);
        mode <= 2'd0;
    endtask
    task automatic t_spi();
        apb(1'b1, PBMX_OFS_DIR, 32'h81);
        apb(1'b1, PBMX_OFS_OUT, 32'h81);
        mode <= 2'd1;
        @(negedge core_clk);
        chk({padOe[7], padPullup[7], padOe[0]}, 3'b011);
        chk({spiClkIn, spiMosiIn, padOut[0]}, {padIn[7], padIn[1], spiMisoOut});
        @(posedge core_clk);
        mode <= 2'd2;
        @(negedge core_clk);
        chk({padOe[7], padOe[0], padPullup[0]}, 3'b101);
        chk({padOut[7], padOut[1], spiMisoIn}, {spiClkOut, spiMosiOut, padIn[0]});
        @(posedge core_clk);
        mode <= 2'd0;
    endtask
    task automatic t_sleep();
        apb(1'b1, PBMX_OFS_DIR, 32'h0);
        apb(1'b1, PBMX_OFS_IRQCTL, 32'h1 << PBMX_IRQ1_EN_BIT);
        padIn <= 8'hff;
        sleepClamp <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(PBMX_OFS_PIN, 32'h04, 1'b0);
        chk({timer1AltCaptureIn, extIrqOneTap, extIrqTwoTap}, 3'b010);
        sleepClamp <= 1'b0;
        analogDigitalOff <= 8'h40;
        @(negedge core_clk);
        chk(timer1AltCaptureIn, 1'b0);
        @(posedge core_clk);
        analogDigitalOff <= 8'h00;
        @(negedge core_clk);
        chk(timer1AltCaptureIn, 1'b1);
        apb(1'b1, PBMX_OFS_IRQCTL, 32'h0);
    endtask
    // Disabled irq two held high through a clamp; low-level sensing must stay quiet
    task automatic t_wake();
        for (int s = 3; s >= 0; s--)
        begin
            apb(1'b1, PBMX_OFS_IRQCTL, 32'(s) << PBMX_IRQ2_SENSE_LO);
            apb(1'b1, PBMX_OFS_IRQFLG, 32'h3);
            sleepClamp <= 1'b1;
            repeat (4) @(posedge core_clk);
            sleepClamp <= 1'b0;
            repeat (4) @(posedge core_clk);
            rd(PBMX_OFS_IRQFLG, (s != 0) ? 32'h2 : 32'h0, 1'b0);
            chk(extIrqFlags, (s != 0) ? 2'h2 : 2'h0);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_gpio();
        t_stage();
        t_spi();
        t_sleep();
        t_wake();
        wrap_up();
    end
    // The whole sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        errors++;
        wrap_up();
    end
endmodule
